// ===== hw/isabc_pkg.sv
// Shared constants, pin bundle and boot window decode for the bus option block.
// Assumes all host pins arrive raw and are synchronised inside the block.
package isabc_pkg;

  // Register address within page 0 and field positions of the option byte
  localparam logic [3:0] ISABC_CFG_B_ADDR   = 4'hB;
  localparam int         ISABC_WIDE_BIT     = 3;
  localparam int         ISABC_CHRDY_BIT    = 4;
  localparam int         ISABC_BERR_BIT     = 5;
  localparam int         ISABC_BOOT_ROM_WRITE_ENABLE_BIT     = 6;
  localparam int         ISABC_EEPROM_LOAD_TRIGGER_BIT   = 7;

  // Reset-loaded byte layout
  localparam int         ISABC_LOCK_BIT     = 7;
  localparam int         ISABC_CORE_CLOCK_SELECT_BIT   = 6;
  localparam int         ISABC_INTERRUPT_DRIVE_MODE_BIT   = 5;
  localparam int         ISABC_COMP_BIT     = 4;
  localparam int         ISABC_WIN_LSB      = 0;
  localparam int         ISABC_WIN_MSB      = 3;

  // Values after reset
  localparam logic       ISABC_BIT_RST      = 1'b0;
  localparam logic [7:0] ISABC_BYTE_RST     = 8'h00;

  // Boot window sizes in bytes
  localparam logic [19:0] ISABC_SZ_8K       = 20'h02000;
  localparam logic [19:0] ISABC_SZ_32K      = 20'h08000;
  localparam logic [19:0] ISABC_SZ_64K      = 20'h10000;

  typedef struct packed {
    logic        bale;
    logic        iord_n;
    logic        iowr_n;
    logic        smemr_n;
    logic        smemw_n;
    logic [19:0] sa;
    logic [7:0]  sd;
    logic [7:0]  msd;
    logic [7:0]  strap;
  } isabc_pins_s;

  typedef struct packed {
    logic        valid;
    logic [19:0] base;
    logic [19:0] size;
  } isabc_win_s;

  // Window select code to base and size; 000X means no boot device
  function automatic isabc_win_s isabc_win_decode(input logic [3:0] code);
    isabc_win_s w;
    w = '{valid: 1'b1, base: 20'h0C000, size: ISABC_SZ_8K};
    case (code)
      4'h2:    w.base = 20'h0C000;
      4'h3:    w.base = 20'h0C400;
      4'h4:    w.base = 20'h0C800;
      4'h5:    w.base = 20'h0CC00;
      4'h6:    w.base = 20'h0D000;
      4'h7:    w.base = 20'h0D400;
      4'h8:    w.base = 20'h0D800;
      4'h9:    w.base = 20'h0DC00;
      4'hA:    w = '{valid: 1'b1, base: 20'h0C000, size: ISABC_SZ_32K};
      4'hB:    w = '{valid: 1'b1, base: 20'h0C800, size: ISABC_SZ_32K};
      4'hC:    w = '{valid: 1'b1, base: 20'h0D000, size: ISABC_SZ_32K};
      4'hD:    w = '{valid: 1'b1, base: 20'h0D800, size: ISABC_SZ_32K};
      4'hE:    w = '{valid: 1'b1, base: 20'h0C000, size: ISABC_SZ_64K};
      4'hF:    w = '{valid: 1'b1, base: 20'h0D000, size: ISABC_SZ_64K};
      default: w.valid = 1'b0;
    endcase
    return w;
  endfunction

  function automatic logic isabc_win_hit(input isabc_win_s w, input logic [19:0] a);
    return w.valid && (a >= w.base) && (a < w.base + w.size);
  endfunction

endpackage

// ===== hw/isabc_bus_option.sv
// Host bus option byte, bus error capture, boot window decode and unlock gate.
// Assumes io_sel and page0 come from the core decoder on clk_sys; pins are raw.
`timescale 1ns/1ps

module isabc_bus_option (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire isabc_pkg::isabc_pins_s pins,
  input  wire logic               io_sel,
  input  wire logic               page0,
  input  wire logic               wait_req,
  output logic                    io16_oe,
  output logic                    chrdy_oe,
  output logic [7:0]              sd_o,
  output logic                    sd_oe,
  output logic                    rom_rd_n,
  output logic                    rom_we_n,
  output logic                    eeprom_load_start,
  output logic                    rbcr1_wr,
  output logic [7:0]              rbcr1_data,
  output logic [7:0]              reset_cfg
);

  isabc_pkg::isabc_pins_s s1_q;
  isabc_pkg::isabc_pins_s s2_q;
  isabc_pkg::isabc_pins_s prev_q;
  isabc_pkg::isabc_win_s  win;
  logic                   cmd_act;
  logic                   cmd_end;
  logic                   rd_end;
  logic                   wr_end;
  logic                   mem_hit;
  logic                   reg_rd;
  logic                   at_cfg;
  logic                   cfg_wr;
  logic                   berr_set;
  logic                   ins_d;
  logic [7:0]             readback;
  logic                   sel_q;
  logic                   page0_q;
  logic [3:0]             addr_q;
  logic [7:0]             wdata_q;
  logic                   unlock_q;
  logic                   bale_seen_q;
  logic                   wide_q;
  logic                   chrdy_mode_q;
  logic                   boot_rom_write_enable_q;
  logic                   berr_q;
  logic                   eel_q;
  logic                   io16_q;
  logic                   chrdy_q;
  logic [7:0]             sd_o_q;
  logic                   sd_oe_q;
  logic                   rom_rd_n_q;
  logic                   rom_we_n_q;
  logic                   rbcr1_wr_q;
  logic [7:0]             rbcr1_data_q;
  logic [7:0]             cfg_c_q;

  // Pins are asynchronous to clk_sys; prev_q feeds edge detection only
  always_ff @(posedge clk_sys) begin
    s1_q   <= pins;
    s2_q   <= s1_q;
    prev_q <= s2_q;
  end

  assign cmd_act = ~s2_q.iord_n | ~s2_q.iowr_n;
  assign rd_end  = ~prev_q.iord_n & s2_q.iord_n;
  assign wr_end  = ~prev_q.iowr_n & s2_q.iowr_n;
  assign cmd_end = rd_end | wr_end;
  assign at_cfg  = page0_q && (addr_q == isabc_pkg::ISABC_CFG_B_ADDR);
  assign cfg_wr  = wr_end && sel_q && at_cfg && unlock_q;
  assign win     = isabc_pkg::isabc_win_decode(
                     cfg_c_q[isabc_pkg::ISABC_WIN_MSB:isabc_pkg::ISABC_WIN_LSB]);
  assign mem_hit = isabc_pkg::isabc_win_hit(win, s2_q.sa);
  assign reg_rd  = ~s2_q.iord_n && io_sel && page0
                   && (s2_q.sa[3:0] == isabc_pkg::ISABC_CFG_B_ADDR);
  // Write enable sits at bit 6, error flag at bit 5
  assign readback = {1'b0, boot_rom_write_enable_q, berr_q, chrdy_mode_q, wide_q, 3'h0};
  // Waits are being inserted while not-ready is driven; ending then is a fault
  assign berr_set = cmd_end && chrdy_q;

  // Strap byte caught every cycle of reset; last value before release sticks
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_c_q <= s2_q.strap;
    end
  end

  // Access context held for the whole strobe so the end edge sees it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_q   <= isabc_pkg::ISABC_BIT_RST;
      page0_q <= isabc_pkg::ISABC_BIT_RST;
      addr_q  <= 4'h0;
      wdata_q <= isabc_pkg::ISABC_BYTE_RST;
    end else if (cmd_act) begin
      sel_q   <= io_sel;
      page0_q <= page0;
      addr_q  <= s2_q.sa[3:0];
      wdata_q <= s2_q.sd;
    end
  end

  // Any register access other than the unlocking read drops the unlock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      unlock_q <= isabc_pkg::ISABC_BIT_RST;
    end else if (cmd_end && sel_q) begin
      unlock_q <= rd_end && at_cfg && !cfg_c_q[isabc_pkg::ISABC_LOCK_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rbcr1_wr_q   <= isabc_pkg::ISABC_BIT_RST;
      rbcr1_data_q <= isabc_pkg::ISABC_BYTE_RST;
    end else begin
      rbcr1_wr_q <= wr_end && sel_q && at_cfg && !unlock_q;
      if (wr_end && sel_q && at_cfg && !unlock_q) begin
        rbcr1_data_q <= wdata_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wide_q       <= isabc_pkg::ISABC_BIT_RST;
      chrdy_mode_q <= isabc_pkg::ISABC_BIT_RST;
      boot_rom_write_enable_q       <= isabc_pkg::ISABC_BIT_RST;
    end else if (cfg_wr) begin
      wide_q       <= wdata_q[isabc_pkg::ISABC_WIDE_BIT];
      chrdy_mode_q <= wdata_q[isabc_pkg::ISABC_CHRDY_BIT];
      boot_rom_write_enable_q       <= wdata_q[isabc_pkg::ISABC_BOOT_ROM_WRITE_ENABLE_BIT];
    end
  end

  // Set beats clear so a fault in the clearing cycle is kept
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      berr_q <= isabc_pkg::ISABC_BIT_RST;
    end else if (berr_set) begin
      berr_q <= 1'b1;
    end else if (cfg_wr && wdata_q[isabc_pkg::ISABC_BERR_BIT]) begin
      berr_q <= 1'b0;
    end
  end

  // Trigger is a pulse, never stored, so it reads back as zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      eel_q <= isabc_pkg::ISABC_BIT_RST;
    end else begin
      eel_q <= cfg_wr && wdata_q[isabc_pkg::ISABC_EEPROM_LOAD_TRIGGER_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bale_seen_q <= isabc_pkg::ISABC_BIT_RST;
    end else if (cmd_end) begin
      bale_seen_q <= 1'b0;
    end else if (s2_q.bale) begin
      bale_seen_q <= 1'b1;
    end
  end

  assign ins_d = io_sel && wait_req && (chrdy_mode_q ? (bale_seen_q || s2_q.bale) : cmd_act);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io16_q  <= isabc_pkg::ISABC_BIT_RST;
      chrdy_q <= isabc_pkg::ISABC_BIT_RST;
    end else begin
      io16_q  <= io_sel && (!wide_q || cmd_act);
      chrdy_q <= ins_d;
    end
  end

  // Register read takes the data bus ahead of a boot window read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sd_o_q     <= isabc_pkg::ISABC_BYTE_RST;
      sd_oe_q    <= isabc_pkg::ISABC_BIT_RST;
      rom_rd_n_q <= 1'b1;
      rom_we_n_q <= 1'b1;
    end else begin
      rom_rd_n_q <= ~(~s2_q.smemr_n && mem_hit);
      rom_we_n_q <= ~(~s2_q.smemw_n && mem_hit && boot_rom_write_enable_q);
      if (reg_rd) begin
        sd_o_q  <= readback;
        sd_oe_q <= 1'b1;
      end else if (~s2_q.smemr_n && mem_hit) begin
        sd_o_q  <= s2_q.msd;
        sd_oe_q <= 1'b1;
      end else begin
        sd_oe_q <= 1'b0;
      end
    end
  end

  assign io16_oe           = io16_q;
  assign chrdy_oe          = chrdy_q;
  assign sd_o              = sd_o_q;
  assign sd_oe             = sd_oe_q;
  assign rom_rd_n          = rom_rd_n_q;
  assign rom_we_n          = rom_we_n_q;
  assign eeprom_load_start = eel_q;
  assign rbcr1_wr          = rbcr1_wr_q;
  assign rbcr1_data        = rbcr1_data_q;
  assign reset_cfg         = cfg_c_q;

  sequence seq_ee_pulse;
    eeprom_load_start ##1 !eeprom_load_start;
  endsequence

  sequence seq_redirect;
    rbcr1_wr_q && (rbcr1_data_q == $past(wdata_q));
  endsequence

  a_io16_strobe_wait: assert property (@(posedge clk_sys) disable iff (srst)
    (io_sel && wide_q && !cmd_act) |=> !io16_oe)
    else $error("wide io asserted before strobe");

  a_io16_decode_only: assert property (@(posedge clk_sys) disable iff (srst)
    (io_sel && !wide_q) |=> io16_oe)
    else $error("wide io missing on decode");

  a_chrdy_strobe_mode: assert property (@(posedge clk_sys) disable iff (srst)
    (!chrdy_mode_q && !cmd_act) |=> !chrdy_oe)
    else $error("not-ready before strobe");

  a_berr_on_cut: assert property (@(posedge clk_sys) disable iff (srst)
    (cmd_end && chrdy_oe) |=> berr_q)
    else $error("bus error not flagged");

  a_berr_clear_one: assert property (@(posedge clk_sys) disable iff (srst)
    (cfg_wr && wdata_q[isabc_pkg::ISABC_BERR_BIT] && !berr_set) |=> !berr_q)
    else $error("bus error not cleared");

  a_berr_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    (berr_q && !(cfg_wr && wdata_q[isabc_pkg::ISABC_BERR_BIT])) |=> berr_q)
    else $error("bus error dropped");

  a_rom_write_block: assert property (@(posedge clk_sys) disable iff (srst)
    !boot_rom_write_enable_q |=> rom_we_n)
    else $error("rom write while disabled");

  a_eeprom_load_trigger_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    (cfg_wr && wdata_q[isabc_pkg::ISABC_EEPROM_LOAD_TRIGGER_BIT]) |=> seq_ee_pulse)
    else $error("eeprom load not one pulse");

  a_unlock_write: assert property (@(posedge clk_sys) disable iff (srst)
    cfg_wr |=> !rbcr1_wr_q && (wide_q == $past(wdata_q[isabc_pkg::ISABC_WIDE_BIT])))
    else $error("unlocked write not taken");

  a_redirect_write: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_end && sel_q && at_cfg && !unlock_q) |=> seq_redirect and $stable(wide_q))
    else $error("locked write not redirected");

  a_rom_read_data: assert property (@(posedge clk_sys) disable iff (srst)
    (!s2_q.smemr_n && mem_hit && !reg_rd) |=> sd_oe && (sd_o == $past(s2_q.msd)))
    else $error("boot read data wrong");

  a_no_rom_window: assert property (@(posedge clk_sys) disable iff (srst)
    (cfg_c_q[3:1] == 3'h0) |-> !mem_hit)
    else $error("window hit with no rom");

endmodule

// ===== sim/isabc_host.sv
// Host side of the expansion bus: IO and memory cycles on the raw pins.
// Assumes the bench merges msd and strap into the pin bundle it hands on.
`timescale 1ns/1ps
module isabc_host (
  input  wire logic                   clk_sys,
  output isabc_pkg::isabc_pins_s      hp,
  output logic                        io_sel,
  output logic                        page0,
  input  wire logic                   io16_oe,
  input  wire logic                   chrdy_oe,
  input  wire logic [7:0]             sd_o,
  input  wire logic                   sd_oe,
  input  wire logic                   rom_rd_n,
  input  wire logic                   rom_we_n
);
  logic       pre_io16;
  logic       pre_rdy;
  logic       mid_io16;
  logic       mid_rdy;
  logic       pg;
  logic       m_oe;
  logic       m_rd;
  logic       m_we;
  logic [7:0] q;

  initial begin
    hp = '1;
    hp.bale = 1'b0;
    io_sel = 1'b0;
    page0 = 1'b0;
    pg = 1'b1;
  end

  // Never waits on ready: a cycle with waits requested ends early on purpose
  task automatic io(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    hp.sa = {16'h0030, a};
    hp.sd = d;
    hp.bale = 1'b1;
    io_sel = 1'b1;
    page0 = pg;
    @(negedge clk_sys);
    hp.bale = 1'b0;
    repeat (3) @(negedge clk_sys);
    pre_io16 = io16_oe;
    pre_rdy = chrdy_oe;
    hp.iowr_n = !wr;
    hp.iord_n = wr;
    repeat (5) @(negedge clk_sys);
    q = sd_o;
    mid_io16 = io16_oe;
    mid_rdy = chrdy_oe;
    hp.iord_n = 1'b1;
    hp.iowr_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    io_sel = 1'b0;
    // Released lines show the inverse, not a stale value
    hp.sd = ~d;
    hp.sa = ~hp.sa;
  endtask

  task automatic mem(input logic wr, input logic [19:0] a);
    @(negedge clk_sys);
    hp.sa = a;
    hp.smemw_n = !wr;
    hp.smemr_n = wr;
    repeat (5) @(negedge clk_sys);
    q = sd_o;
    m_oe = sd_oe;
    m_rd = rom_rd_n;
    m_we = rom_we_n;
    hp.smemr_n = 1'b1;
    hp.smemw_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    hp.sa = ~a;
  endtask
endmodule

// ===== sim/test_isa_bus_option_and_boot_rom_config.sv
// Self-checking bench for the bus option block with a host model.
// Assumes the design package and block are compiled first.
`timescale 1ns/1ps
module test_isa_bus_option_and_boot_rom_config;
  logic                   clk_sys, srst, wait_req, io_sel, page0, io16_oe, chrdy_oe;
  logic                   sd_oe, rom_rd_n, rom_we_n, eeprom_load_start, rbcr1_wr;
  logic [7:0]             msd, strap, sd_o, rbcr1_data, reset_cfg, last_rb;
  isabc_pkg::isabc_pins_s hp, pins;
  int                     errors, n_checks, n_load, n_rb, cyc;
  logic [7:0]             w_code [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'h00};
  logic [19:0]            w_addr [6] = '{20'h0C400, 20'h0C3FF, 20'h0E3FF, 20'h0E400,
                                         20'h0C000, 20'h0C000};
  logic                   w_hit  [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  always_comb begin
    pins = hp;
    pins.msd = msd;
    pins.strap = strap;
  end

  isabc_bus_option dut (
    .clk_sys(clk_sys), .srst(srst), .pins(pins), .io_sel(io_sel), .page0(page0),
    .wait_req(wait_req), .io16_oe(io16_oe), .chrdy_oe(chrdy_oe), .sd_o(sd_o),
    .sd_oe(sd_oe), .rom_rd_n(rom_rd_n), .rom_we_n(rom_we_n),
    .eeprom_load_start(eeprom_load_start), .rbcr1_wr(rbcr1_wr),
    .rbcr1_data(rbcr1_data), .reset_cfg(reset_cfg));

  isabc_host host (
    .clk_sys(clk_sys), .hp(hp), .io_sel(io_sel), .page0(page0), .io16_oe(io16_oe),
    .chrdy_oe(chrdy_oe), .sd_o(sd_o), .sd_oe(sd_oe), .rom_rd_n(rom_rd_n),
    .rom_we_n(rom_we_n));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (eeprom_load_start === 1'b1) n_load <= n_load + 1;
    if (rbcr1_wr === 1'b1) begin
      n_rb <= n_rb + 1;
      last_rb <= rbcr1_data;
    end
    if (cyc == 4000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Straps chosen by the bench never preset the load trigger
  task automatic do_reset(input logic [7:0] s);
    strap = s;
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    check(reset_cfg, s);
  endtask

  task automatic rd_b(input logic [7:0] exp);
    host.io(1'b0, isabc_pkg::ISABC_CFG_B_ADDR, 8'h00);
    check(host.q, exp);
  endtask

  task automatic wr_b(input logic [7:0] d);
    host.io(1'b1, isabc_pkg::ISABC_CFG_B_ADDR, d);
  endtask

  task automatic t_rom_write(input logic exp_we);
    host.mem(1'b1, 20'h0C010);
    check(8'(host.m_we), 8'(exp_we));
  endtask

  task automatic t_bus_error();
    wait_req = 1'b1;
    host.io(1'b0, 4'h0, 8'h00);
    wait_req = 1'b0;
    check(8'(host.pre_rdy), 8'h00);
    check(8'(host.pre_io16), 8'h01);
    check(8'(host.mid_rdy), 8'h01);
    rd_b(8'h20);
    wr_b(8'h58);
    rd_b(8'h78);
    wait_req = 1'b1;
    host.io(1'b0, 4'h0, 8'h00);
    wait_req = 1'b0;
    check(8'(host.pre_rdy), 8'h01);
    check(8'(host.pre_io16), 8'h00);
    check(8'(host.mid_io16), 8'h01);
    rd_b(8'h78);
    wr_b(8'h78);
    rd_b(8'h58);
  endtask

  task automatic t_unlock();
    host.io(1'b0, 4'h0, 8'h00);
    wr_b(8'h3C);
    check(8'(n_rb), 8'h01);
    check(last_rb, 8'h3C);
    rd_b(8'h58);
    wr_b(8'hD8);
    check(8'(n_load), 8'h01);
    rd_b(8'h58);
    check(8'(n_rb), 8'h01);
    // A page 1 access between read and write also drops the unlock
    host.pg = 1'b0;
    host.io(1'b0, isabc_pkg::ISABC_CFG_B_ADDR, 8'h00);
    host.pg = 1'b1;
    wr_b(8'h18);
    check(8'(n_rb), 8'h02);
    check(last_rb, 8'h18);
    rd_b(8'h58);
  endtask

  // Lock strap set: reading B never opens it, so writes are redirected
  task automatic t_lock();
    do_reset(8'h82);
    rd_b(8'h00);
    wr_b(8'h48);
    check(8'(n_rb), 8'h03);
    check(last_rb, 8'h48);
    rd_b(8'h00);
  endtask

  task automatic t_rom_read();
    host.mem(1'b0, 20'h0DFFF);
    check(host.q, 8'hA5);
    check(8'(host.m_rd), 8'h00);
  endtask

  task automatic t_window();
    for (int i = 0; i < 6; i++) begin
      do_reset(w_code[i]);
      msd = 8'h30 + 8'(i);
      host.mem(1'b0, w_addr[i]);
      check(8'(host.m_oe), 8'(w_hit[i]));
      check(8'(host.m_rd), 8'(!w_hit[i]));
      if (w_hit[i]) check(host.q, msd);
    end
  endtask

  initial begin
    srst = 1'b1;
    wait_req = 1'b0;
    msd = 8'hA5;
    strap = 8'h72;
    do_reset(8'h72);
    rd_b(8'h00);
    t_rom_write(1'b1);
    t_rom_read();
    t_bus_error();
    t_rom_write(1'b0);
    t_unlock();
    t_lock();
    t_window();
    final_report();
  end
endmodule
